/* core/mpms_defs.svh */
// Function
// - Type straps float or ground, low asserted
// - Watchdog expiry output asserts after timeout
// - Speaker control output drives external switch
// - Lid input active low, reported event
// - Sleep button active low, sleeps or wakes
// - Fan speed set by PWM duty
// - Tachometer gives two pulses per revolution
// - Presence input active high, default low
// - Four outputs, four pulled-up inputs
// - Power button falling edge wakes soft-off
// - Reset button low requests reset, reboot
// - Carrier reset output driven low resets
// - Suspend status asserts before low power
// - RAM suspend output low in S3
// - S4, S5 outputs low in state
// - Overtemp alarm low may trigger throttling
// - Overheat trip forces soft-off at once
`ifndef MPMS_DEFS_SVH
`define MPMS_DEFS_SVH
// Register byte offsets
`define MPMS_CTRL_OFS 8'h00
`define MPMS_GPO_OFS 8'h04
`define MPMS_FAN_OFS 8'h08
`define MPMS_WLOAD_OFS 8'h0C
`define MPMS_WKICK_OFS 8'h10
`define MPMS_STAT_OFS 8'h14
`define MPMS_EVT_OFS 8'h18
`define MPMS_TACH_OFS 8'h1C
// Control fields
`define MPMS_CTRL_BEEP 0
`define MPMS_CTRL_WDEN 1
`define MPMS_CTRL_TRIP 2
`define MPMS_CTRL_SREQ 3
`define MPMS_CTRL_TGT 5:4
// Event bits
`define MPMS_EV_LID 0
`define MPMS_EV_SLEEP 1
`define MPMS_EV_PWRKEY 2
`define MPMS_EV_RESET 3
`define MPMS_EV_WAKE 4
`define MPMS_EV_BATT 5
`define MPMS_EV_HOT 6
// Reset values
`define MPMS_WLOAD_RST 24'hFFFFFF
`define MPMS_FAN_RST 8'h80
// Timing
`define MPMS_CLK_NS 10
`define MPMS_WARN_NS 1000000
`define MPMS_TACH_NS 1000000000
`define MPMS_RST_PULSE 8'h64
`endif

/* core/mpms_pkg.sv */
`default_nettype none
package mpms_pkg;
	// Power states of the module
	typedef enum logic [2:0] {MPMS_OFF, MPMS_RUN, MPMS_WARN, MPMS_RAM, MPMS_DISK} mpms_pstate_t;
	// Sideband inputs sampled from the carrier
	typedef struct packed {
		logic       power_good;
		logic [1:0] boot_sel_n;
		logic       cover_n;
		logic       sleep_n;
		logic [3:0] gpi;
		logic       presence;
		logic       tach;
		logic       hot_n;
		logic       pwrkey_n;
		logic       rstbtn_n;
		logic       wake_n;
		logic       batt_n;
	} mpms_pins_t;
endpackage : mpms_pkg
`default_nettype wire

/* core/mpms_sideband.sv */
`include "mpms_defs.svh"
`default_nettype none
module mpms_sideband import mpms_pkg::*; #(
	parameter logic [3:0] STRAP_GND   = 4'h1,
	parameter int         WARN_CYCLES = (`MPMS_WARN_NS + `MPMS_CLK_NS - 1) / `MPMS_CLK_NS,
	parameter int         TACH_CYCLES = `MPMS_TACH_NS / `MPMS_CLK_NS
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write channels
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Pin-out straps, open drain
	output logic             pinout_strap0_n_o,
	output logic             pinout_strap0_n_oe,
	output logic             pinout_strap1_n_o,
	output logic             pinout_strap1_n_oe,
	output logic             pinout_strap2_n_o,
	output logic             pinout_strap2_n_oe,
	output logic             compact_pinout_strap_n_o,
	output logic             compact_pinout_strap_n_oe,
	// Carrier inputs
	input  wire logic        power_good,
	input  wire logic        boot_select0_n,
	input  wire logic        boot_select1_n,
	input  wire logic        cover_closed_n,
	input  wire logic        sleep_button_n,
	input  wire logic [3:0]  general_in,
	input  wire logic        presence_assert,
	input  wire logic        fan_speed_pulse_in,
	input  wire logic        overtemp_alarm_n,
	input  wire logic        power_button_n,
	input  wire logic        reset_button_n,
	input  wire logic        wakeup_request_n,
	input  wire logic        battery_weak_n,
	// Module outputs
	output logic             speaker_drive,
	output logic             watchdog_expired_out,
	output logic             fan_speed_drive_o,
	output logic             fan_speed_drive_oe,
	output logic [3:0]       general_out,
	output logic             carrier_reset_out_n,
	output logic             lowpower_pending_n,
	output logic             ram_suspend_state_n,
	output logic             disk_suspend_state_n,
	output logic             soft_off_state_n,
	output logic             overheat_shutdown_n,
	output logic             throttle_active
);
	// Whole module state
	typedef struct packed {
		mpms_pins_t   s1;       // First sync stage
		mpms_pins_t   s2;       // Second sync stage
		mpms_pins_t   s3;       // Edge history
		logic         aw_got;   // Write address held
		logic         w_got;    // Write data held
		logic [7:0]   awaddr;   // Held write address
		logic [31:0]  wdata;    // Held write data
		logic [3:0]   wstrb;    // Held strobes
		logic         bvalid;   // Write answer pending
		logic [1:0]   bresp;    // Write answer code
		logic         rvalid;   // Read answer pending
		logic [1:0]   rresp;    // Read answer code
		logic [31:0]  rdata;    // Read data
		logic [5:0]   ctrl;     // Control register
		logic [3:0]   gpo;      // General outputs
		logic [7:0]   duty;     // Fan duty
		logic [23:0]  wload;    // Watchdog reload
		logic [23:0]  wcnt;     // Watchdog count
		logic         wexp;     // Watchdog expired
		logic [6:0]   events;   // Sticky events
		logic [7:0]   pwm_cnt;  // Fan PWM phase
		logic         pwm_hi;   // Fan line released
		logic [31:0]  twin;     // Tach window count
		logic [15:0]  tpul;     // Tach pulses this window
		logic [15:0]  trev;     // Revolutions last window
		mpms_pstate_t pst;      // Power state
		logic [1:0]   tgt;      // Pending sleep target
		logic [31:0]  wcyc;     // Warning time count
		logic [7:0]   rst_cnt;  // Carrier reset pulse
		logic         cb_rst;   // Carrier reset active
		logic         ram_act;  // S3 output active
		logic         disk_act; // S4 output active
		logic         off_act;  // S5 output active
		logic         pend_act; // Suspend status active
		logic         thr;      // Throttling
	} mpms_state_t;

	mpms_state_t r_reg;   // Registered state
	mpms_state_t r_next;  // Next state
	mpms_pins_t  pins;    // Raw pin vector

	// Gather raw pins
	assign pins = '{power_good, {boot_select1_n, boot_select0_n}, cover_closed_n, sleep_button_n,
		general_in, presence_assert, fan_speed_pulse_in, overtemp_alarm_n, power_button_n,
		reset_button_n, wakeup_request_n, battery_weak_n};

	// Next state logic
	always_comb begin
		logic [31:0] m;
		logic [6:0]  ev_set;
		logic [6:0]  ev_clr;
		logic        sreq;
		logic        wk;
		m = '0;
		ev_set = '0;
		ev_clr = '0;
		sreq = 1'b0;
		wk = 1'b0;
		r_next = r_reg;
		// Two-flop synchroniser plus history
		r_next.s1 = pins;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		// Write channels taken independently
		if (s_axi_awvalid && s_axi_awready) begin
			r_next.aw_got = 1'b1;
			r_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			r_next.w_got = 1'b1;
			r_next.wdata = s_axi_wdata;
			r_next.wstrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end
		// Perform write once both halves held
		if (r_reg.aw_got && r_reg.w_got) begin
			m = {{8{r_reg.wstrb[3]}}, {8{r_reg.wstrb[2]}}, {8{r_reg.wstrb[1]}}, {8{r_reg.wstrb[0]}}};
			r_next.aw_got = 1'b0;
			r_next.w_got = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = 2'h0;
			unique case ({r_reg.awaddr[7:2], 2'h0})
				`MPMS_CTRL_OFS: begin
					r_next.ctrl = (r_reg.ctrl & ~m[5:0]) | (r_reg.wdata[5:0] & m[5:0]);
					r_next.ctrl[`MPMS_CTRL_SREQ] = 1'b0;
					sreq = r_reg.wdata[`MPMS_CTRL_SREQ] & m[`MPMS_CTRL_SREQ];
				end
				`MPMS_GPO_OFS: r_next.gpo = (r_reg.gpo & ~m[3:0]) | (r_reg.wdata[3:0] & m[3:0]);
				`MPMS_FAN_OFS: r_next.duty = (r_reg.duty & ~m[7:0]) | (r_reg.wdata[7:0] & m[7:0]);
				`MPMS_WLOAD_OFS: r_next.wload = (r_reg.wload & ~m[23:0]) | (r_reg.wdata[23:0] & m[23:0]);
				`MPMS_WKICK_OFS: wk = 1'b1;
				`MPMS_EVT_OFS: ev_clr = r_reg.wdata[6:0] & m[6:0];
				`MPMS_STAT_OFS, `MPMS_TACH_OFS: r_next.bresp = 2'h0;
				default: r_next.bresp = 2'h2;
			endcase
		end
		// Read channel
		if (s_axi_rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = 2'h0;
			r_next.rdata = '0;
			unique case ({s_axi_araddr[7:2], 2'h0})
				`MPMS_CTRL_OFS: r_next.rdata[5:0] = r_reg.ctrl;
				`MPMS_GPO_OFS: r_next.rdata[3:0] = r_reg.gpo;
				`MPMS_FAN_OFS: r_next.rdata[7:0] = r_reg.duty;
				`MPMS_WLOAD_OFS: r_next.rdata[23:0] = r_reg.wload;
				`MPMS_WKICK_OFS: r_next.rdata[23:0] = r_reg.wcnt;
				// Live state: pins, power state, flags
				`MPMS_STAT_OFS: r_next.rdata[14:0] = {r_reg.s2.batt_n, r_reg.wexp, r_reg.thr,
					r_reg.s2.boot_sel_n, r_reg.s2.presence, ~r_reg.s2.cover_n,
					r_reg.s2.gpi, r_reg.s2.power_good, r_reg.pst};
				`MPMS_EVT_OFS: r_next.rdata[6:0] = r_reg.events;
				`MPMS_TACH_OFS: r_next.rdata[15:0] = r_reg.trev;
				default: r_next.rresp = 2'h2;
			endcase
		end
		// Falling edges of active-low inputs become events
		ev_set[`MPMS_EV_LID] = r_reg.s3.cover_n & ~r_reg.s2.cover_n;
		ev_set[`MPMS_EV_SLEEP] = r_reg.s3.sleep_n & ~r_reg.s2.sleep_n;
		ev_set[`MPMS_EV_PWRKEY] = r_reg.s3.pwrkey_n & ~r_reg.s2.pwrkey_n;
		ev_set[`MPMS_EV_RESET] = r_reg.s3.rstbtn_n & ~r_reg.s2.rstbtn_n;
		ev_set[`MPMS_EV_WAKE] = r_reg.s3.wake_n & ~r_reg.s2.wake_n;
		ev_set[`MPMS_EV_BATT] = r_reg.s3.batt_n & ~r_reg.s2.batt_n;
		ev_set[`MPMS_EV_HOT] = r_reg.s3.hot_n & ~r_reg.s2.hot_n;
		// Set beats a simultaneous clear
		r_next.events = (r_reg.events & ~ev_clr) | ev_set;
		// Throttle while the alarm is held low
		r_next.thr = ~r_reg.s2.hot_n;
		// Watchdog countdown, expiry sticky until kick
		if (wk) begin
			r_next.wcnt = r_reg.wload;
			r_next.wexp = 1'b0;
		end else if (r_reg.ctrl[`MPMS_CTRL_WDEN] && r_reg.wcnt != 24'h0) begin
			r_next.wcnt = r_reg.wcnt - 24'h1;
		end
		if (r_reg.ctrl[`MPMS_CTRL_WDEN] && r_reg.wcnt == 24'h1) begin
			r_next.wexp = 1'b1;
		end
		// Fan PWM, line released while phase below duty
		r_next.pwm_cnt = r_reg.pwm_cnt + 8'h1;
		r_next.pwm_hi = r_reg.pwm_cnt < r_reg.duty;
		// Tach: count rising edges per window, two per turn
		if (r_reg.s2.tach && !r_reg.s3.tach) begin
			r_next.tpul = r_reg.tpul + 16'h1;
		end
		if (r_reg.twin == 32'h0) begin
			r_next.twin = 32'(TACH_CYCLES - 1);
			r_next.tpul = {15'h0, r_reg.s2.tach && !r_reg.s3.tach}; // Boundary edge not lost
			r_next.trev = {1'b0, r_reg.tpul[15:1]};
		end else begin
			r_next.twin = r_reg.twin - 32'h1;
		end
		// Reset button starts a carrier reset pulse
		if (ev_set[`MPMS_EV_RESET]) begin
			r_next.rst_cnt = `MPMS_RST_PULSE;
		end else if (r_reg.rst_cnt != 8'h0) begin
			r_next.rst_cnt = r_reg.rst_cnt - 8'h1;
		end
		// Power state machine
		unique case (r_reg.pst)
			MPMS_OFF: begin
				if (ev_set[`MPMS_EV_PWRKEY]) begin
					r_next.pst = MPMS_RUN;
				end
			end
			MPMS_RUN: begin
				if (sreq || ev_set[`MPMS_EV_SLEEP]) begin
					r_next.pst = MPMS_WARN;
					r_next.tgt = sreq ? r_reg.wdata[`MPMS_CTRL_TGT] : 2'h1;
					r_next.wcyc = 32'(WARN_CYCLES - 1);
				end
			end
			MPMS_WARN: begin
				if (r_reg.wcyc != 32'h0) begin
					r_next.wcyc = r_reg.wcyc - 32'h1;
				end else if (r_reg.tgt == 2'h1) begin
					r_next.pst = MPMS_RAM;
				end else if (r_reg.tgt == 2'h2) begin
					r_next.pst = MPMS_DISK;
				end else if (r_reg.tgt == 2'h3) begin
					r_next.pst = MPMS_OFF;
				end else begin
					r_next.pst = MPMS_RUN;
				end
			end
			MPMS_RAM, MPMS_DISK: begin
				if (ev_set[`MPMS_EV_PWRKEY] || ev_set[`MPMS_EV_SLEEP] || ev_set[`MPMS_EV_WAKE]) begin
					r_next.pst = MPMS_RUN;
				end
			end
			default: r_next.pst = MPMS_OFF;
		endcase
		// Overheat trip overrides everything
		if (r_reg.ctrl[`MPMS_CTRL_TRIP]) begin
			r_next.pst = MPMS_OFF;
		end
		// Registered state outputs
		r_next.ram_act = r_next.pst == MPMS_RAM;
		r_next.disk_act = r_next.pst == MPMS_DISK;
		r_next.off_act = r_next.pst == MPMS_OFF;
		r_next.pend_act = r_next.pst inside {MPMS_WARN, MPMS_RAM, MPMS_DISK};
		r_next.cb_rst = r_next.pst != MPMS_RUN || r_next.rst_cnt != 8'h0 || !r_reg.s2.power_good;
	end

	// State register, synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '0;
			r_reg.duty <= `MPMS_FAN_RST;
			r_reg.wload <= `MPMS_WLOAD_RST;
			r_reg.wcnt <= `MPMS_WLOAD_RST;
			r_reg.off_act <= 1'b1;
			r_reg.cb_rst <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// Bus handshakes
	assign s_axi_awready = !r_reg.aw_got && !r_reg.bvalid;
	assign s_axi_wready = !r_reg.w_got && !r_reg.bvalid;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_arready = !r_reg.rvalid;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rresp = r_reg.rresp;
	assign s_axi_rdata = r_reg.rdata;
	// Straps pull low where grounded, else float
	assign pinout_strap0_n_o = 1'b0;
	assign pinout_strap0_n_oe = STRAP_GND[0];
	assign pinout_strap1_n_o = 1'b0;
	assign pinout_strap1_n_oe = STRAP_GND[1];
	assign pinout_strap2_n_o = 1'b0;
	assign pinout_strap2_n_oe = STRAP_GND[2];
	assign compact_pinout_strap_n_o = 1'b0;
	assign compact_pinout_strap_n_oe = STRAP_GND[3];
	// Module outputs from flops, fan drive level tied low
	assign speaker_drive = r_reg.ctrl[`MPMS_CTRL_BEEP];
	assign watchdog_expired_out = r_reg.wexp;
	assign fan_speed_drive_o = 1'b0;
	assign fan_speed_drive_oe = ~r_reg.pwm_hi;
	assign general_out = r_reg.gpo;
	assign carrier_reset_out_n = ~r_reg.cb_rst;
	assign lowpower_pending_n = ~r_reg.pend_act;
	assign ram_suspend_state_n = ~r_reg.ram_act;
	assign disk_suspend_state_n = ~r_reg.disk_act;
	assign soft_off_state_n = ~r_reg.off_act;
	assign overheat_shutdown_n = ~r_reg.ctrl[`MPMS_CTRL_TRIP];
	assign throttle_active = r_reg.thr;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_TRIP_OFF: assert property ($fell(overheat_shutdown_n) |=> !soft_off_state_n)
		else $error("trip did not force soft-off");
	AST_PWRKEY_WAKE: assert property ((r_reg.pst == MPMS_OFF && !r_reg.ctrl[`MPMS_CTRL_TRIP]
		&& r_reg.s3.pwrkey_n && !r_reg.s2.pwrkey_n) |=> ##1 soft_off_state_n)
		else $error("power button did not wake");
	AST_S3_OUT: assert property ($rose(r_reg.pst == MPMS_RAM) |-> !ram_suspend_state_n)
		else $error("S3 output not low in RAM suspend");
	AST_S4_OUT: assert property (!disk_suspend_state_n |-> r_reg.pst == MPMS_DISK)
		else $error("S4 output low outside disk suspend");
	AST_WARN: assert property ($rose(r_reg.pst == MPMS_WARN) |-> !lowpower_pending_n
		until (r_reg.pst != MPMS_WARN))
		else $error("suspend status not held in warning");
	AST_RST_PULSE: assert property ((r_reg.s3.rstbtn_n && !r_reg.s2.rstbtn_n)
		|=> ##1 !carrier_reset_out_n [*4])
		else $error("reset button gave no carrier reset");
	AST_WDOG: assert property ((r_reg.ctrl[`MPMS_CTRL_WDEN] && r_reg.wcnt == 24'h1)
		|=> watchdog_expired_out)
		else $error("watchdog expiry missing");
	AST_FAN: assert property ((r_reg.duty == 8'h0) [*2] |-> fan_speed_drive_oe)
		else $error("fan line released at zero duty");
	AST_LID: assert property ((r_reg.s3.cover_n && !r_reg.s2.cover_n)
		|=> r_reg.events[`MPMS_EV_LID])
		else $error("lid event lost");
	AST_SLEEP: assert property ((r_reg.pst == MPMS_RUN && !r_reg.ctrl[`MPMS_CTRL_TRIP]
		&& r_reg.s3.sleep_n && !r_reg.s2.sleep_n) |=> ##1 !lowpower_pending_n)
		else $error("sleep button did not start suspend");
endmodule : mpms_sideband
`default_nettype wire

/* testbench/mpms_carrier_model.sv */
`default_nettype none
module mpms_carrier_model #(
	parameter logic [3:0] TYPE_OK  = 4'hE,
	parameter int         PG_DELAY = 4
) (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Module straps and sleep line
	input  wire logic [3:0] strap_oe,
	input  wire logic       ram_suspend_state_n,
	// Bench controls
	input  wire logic       init_done,
	input  wire logic       pres_on,
	input  wire logic [1:0] boot_low,
	// Lines towards the module
	output logic            power_good,
	output logic            supply_on_request_n,
	output logic            boot_select0_n,
	output logic            boot_select1_n,
	output logic            presence_assert
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] strap_lvl;           // Strap wires with carrier pull-ups
	logic       compat;              // Module layout matches this carrier
	logic [1:0] s3_sync = 2'h3;      // Synchroniser for the sleep line
	int         pg_cnt  = 0;         // Supply settling count
	// Grounded strap reads low, open strap reads high
	assign strap_lvl = ~strap_oe;
	// Open compact strap means revision 2.0 layout, grounded means compact type
	assign compat = (strap_lvl === TYPE_OK);
	// Supply held off for a foreign layout, in RAM suspend or before init
	assign supply_on_request_n = ~(compat && init_done && s3_sync[1]);
	// Boot straps only float or go low, and float until rails are up
	assign boot_select0_n = (power_good && boot_low[0]) ? 1'h0 : 1'h1;
	assign boot_select1_n = (power_good && boot_low[1]) ? 1'h0 : 1'h1;
	// Open presence line is held low by the pull-down
	assign presence_assert = pres_on;
	// Power good rises only after supply has settled
	always @(posedge aclk) begin
		s3_sync <= {s3_sync[0], ram_suspend_state_n};
		if (supply_on_request_n !== 1'h0) begin
			pg_cnt <= 0;
		end else if (pg_cnt < PG_DELAY) begin
			pg_cnt <= pg_cnt + 1;
		end
	end
	assign power_good = (pg_cnt == PG_DELAY);
endmodule : mpms_carrier_model
`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] STRAP = 4'h1;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} mpms_row_t;
	// Register bus
	logic aclk = 1'h0, aresetn = 1'h0, init_done = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF, general_in = 4'hF, general_out;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	// Straps and sideband
	logic pinout_strap0_n_o, pinout_strap0_n_oe, pinout_strap1_n_o, pinout_strap1_n_oe;
	logic pinout_strap2_n_o, pinout_strap2_n_oe, compact_pinout_strap_n_o, compact_pinout_strap_n_oe;
	logic power_good, boot_select0_n, boot_select1_n, presence_assert, supply_on_request_n;
	logic [6:0] sb_n = 7'h7F;        // Button and alarm lines, event bit order
	logic       pres = 1'h1;         // Presence line from the carrier
	logic cover_closed_n, sleep_button_n, power_button_n, reset_button_n;
	logic wakeup_request_n, battery_weak_n, overtemp_alarm_n, fan_speed_pulse_in = 1'h0;
	logic speaker_drive, watchdog_expired_out, fan_speed_drive_o, fan_speed_drive_oe;
	logic carrier_reset_out_n, lowpower_pending_n, ram_suspend_state_n, disk_suspend_state_n;
	logic soft_off_state_n, overheat_shutdown_n, throttle_active;
	int errors = 0, num_checks = 0, n;
	logic [2:0] lo_exp [3] = '{3'h6, 3'h5, 3'h3};   // Sleep lines per target
	int         wk     [3] = '{1, 4, 2};            // Wake line per target
	int         ev     [4] = '{0, 3, 5, 6};         // Event lines exercised
	mpms_row_t rows [10] = '{
		'{1'h0, 8'h00, 32'h0, 32'h0, 2'h0}, '{1'h0, 8'h04, 32'h0, 32'h0, 2'h0},
		'{1'h0, 8'h08, 32'h0, 32'h80, 2'h0}, '{1'h0, 8'h0C, 32'h0, 32'hFFFFFF, 2'h0},
		'{1'h1, 8'h04, 32'h5, 32'h0, 2'h0}, '{1'h0, 8'h04, 32'h0, 32'h5, 2'h0},
		'{1'h1, 8'h08, 32'h40, 32'h0, 2'h0}, '{1'h0, 8'h08, 32'h0, 32'h40, 2'h0},
		'{1'h1, 8'h20, 32'hA, 32'h0, 2'h2}, '{1'h0, 8'h20, 32'h0, 32'h0, 2'h2}};
	assign {overtemp_alarm_n, battery_weak_n, wakeup_request_n, reset_button_n} = sb_n[6:3];
	assign {power_button_n, sleep_button_n, cover_closed_n} = sb_n[2:0];
	mpms_sideband #(.STRAP_GND(STRAP), .WARN_CYCLES(8), .TACH_CYCLES(64)) dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pinout_strap0_n_o, .pinout_strap0_n_oe,
		.pinout_strap1_n_o, .pinout_strap1_n_oe, .pinout_strap2_n_o, .pinout_strap2_n_oe,
		.compact_pinout_strap_n_o, .compact_pinout_strap_n_oe, .power_good, .boot_select0_n,
		.boot_select1_n, .cover_closed_n, .sleep_button_n, .general_in, .presence_assert,
		.fan_speed_pulse_in, .overtemp_alarm_n, .power_button_n, .reset_button_n,
		.wakeup_request_n, .battery_weak_n, .speaker_drive, .watchdog_expired_out,
		.fan_speed_drive_o, .fan_speed_drive_oe, .general_out, .carrier_reset_out_n,
		.lowpower_pending_n, .ram_suspend_state_n, .disk_suspend_state_n, .soft_off_state_n,
		.overheat_shutdown_n, .throttle_active);
	mpms_carrier_model #(.TYPE_OK(~STRAP)) carrier (
		.aclk, .aresetn, .ram_suspend_state_n, .init_done, .pres_on(pres), .boot_low(2'h1),
		.strap_oe({compact_pinout_strap_n_oe, pinout_strap2_n_oe, pinout_strap1_n_oe,
			pinout_strap0_n_oe}), .power_good, .supply_on_request_n, .boot_select0_n,
		.boot_select1_n, .presence_assert);
	// Clock, fan tachometer with two pulses per turn
	always #5 aclk = ~aclk;
	always begin
		repeat (4) @(posedge aclk);
		fan_speed_pulse_in <= ~fan_speed_pulse_in;
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wt(input int c);
		repeat (c) @(posedge aclk);
		#1;
	endtask : wt
	task automatic pin(input int b, input logic v);
		@(posedge aclk);
		sb_n[b] <= v;
		wt(6);
	endtask : pin
	// Write both halves, release each when taken, hold bready until answer
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad = 1'h0, wd = 1'h0, bd = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (int i = 0; i < 64 && !bd; i++) begin
			@(negedge aclk);
			ad = ad | (s_axi_awvalid & s_axi_awready);
			wd = wd | (s_axi_wvalid & s_axi_wready);
			bd = (s_axi_bvalid === 1'h1);
			r = s_axi_bresp;
			@(posedge aclk);
			if (ad) s_axi_awvalid <= 1'h0;
			if (wd) s_axi_wvalid <= 1'h0;
			if (bd) s_axi_bready <= 1'h0;
		end
		if (!bd) chk("bvalid", 32'h0, 32'h1);
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ad = 1'h0, dd = 1'h0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (int i = 0; i < 64 && !dd; i++) begin
			@(negedge aclk);
			ad = ad | (s_axi_arvalid & s_axi_arready);
			dd = (s_axi_rvalid === 1'h1);
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ad) s_axi_arvalid <= 1'h0;
			if (dd) s_axi_rready <= 1'h0;
		end
		if (!dd) chk("rvalid", 32'h0, 32'h1);
	endtask : axr
	// Outputs held by reset, straps constant
	task automatic rst_chk;
		chk("reset outs", {16'h0, soft_off_state_n, carrier_reset_out_n, lowpower_pending_n,
			ram_suspend_state_n, disk_suspend_state_n, speaker_drive, watchdog_expired_out,
			general_out, s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid,
			s_axi_rvalid}, 32'h381C);
		chk("straps", {24'h0, compact_pinout_strap_n_oe, pinout_strap2_n_oe, pinout_strap1_n_oe,
			pinout_strap0_n_oe, compact_pinout_strap_n_o, pinout_strap2_n_o, pinout_strap1_n_o,
			pinout_strap0_n_o}, {24'h0, STRAP, 4'h0});
	endtask : rst_chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	// Hang guard
	initial begin
		#200000;
		errors++;
		wrap_up();
	end
	initial begin
		wt(16);
		rst_chk();
		@(posedge aclk);
		aresetn <= 1'h1;
		init_done <= 1'h1;
		wt(8);
		foreach (rows[i]) begin
			if (rows[i].w) axw(rows[i].a, rows[i].d, rs);
			else axr(rows[i].a, rd, rs);
			if (!rows[i].w) chk("rdata", rd, rows[i].e);
			chk("resp", {30'h0, rs}, {30'h0, rows[i].r});
		end
		wt(1);
		chk("gpo", {28'h0, general_out}, 32'h5);
		n = 0;
		repeat (256) begin
			@(negedge aclk);
			if (fan_speed_drive_oe === 1'h0) n++;
		end
		chk("pwm released", n, 32'h40);
		chk("pwm level", {31'h0, fan_speed_drive_o}, 32'h0);
		axr(8'h1C, rd, rs);
		chk("tach", rd, 32'h4);
		$display("register table test done");
		pin(2, 1'h0);
		pin(2, 1'h1);
		chk("run lines", {30'h0, soft_off_state_n, carrier_reset_out_n}, 32'h3);
		axr(8'h14, rd, rs);
		chk("status", {17'h0, rd[14:0]}, 32'h4AF9);
		@(posedge aclk);
		pres <= 1'h0;
		wt(3);
		axr(8'h14, rd, rs);
		chk("absent", {31'h0, rd[9]}, 32'h0);
		pres <= 1'h1;
		pin(6, 1'h0);
		pin(5, 1'h0);
		chk("throttle on", {31'h0, throttle_active}, 32'h1);
		axr(8'h14, rd, rs);
		chk("alarm status", {29'h0, rd[14:12]}, 32'h1);
		pin(6, 1'h1);
		pin(5, 1'h1);
		chk("throttle off", {31'h0, throttle_active}, 32'h0);
		$display("power on test done");
		pin(3, 1'h0);
		chk("carrier_reset_out_n low", {31'h0, carrier_reset_out_n}, 32'h0);
		pin(3, 1'h1);
		wt(80);
		chk("carrier_reset_out_n held", {31'h0, carrier_reset_out_n}, 32'h0);
		wt(20);
		chk("carrier_reset_out_n end", {31'h0, carrier_reset_out_n}, 32'h1);
		axw(8'h18, 32'h7F, rs);
		foreach (ev[i]) begin
			pin(ev[i], 1'h0);
			pin(ev[i], 1'h1);
			axr(8'h18, rd, rs);
			chk("event", rd, 32'h1 << ev[i]);
			axw(8'h18, 32'h1 << ev[i], rs);
		end
		axr(8'h18, rd, rs);
		chk("events clear", rd, 32'h0);
		$display("event test done");
		axw(8'h0C, 32'h14, rs);
		axw(8'h10, 32'h0, rs);
		axw(8'h00, 32'h3, rs);
		wt(5);
		chk("speaker", {31'h0, speaker_drive}, 32'h1);
		chk("wdog early", {31'h0, watchdog_expired_out}, 32'h0);
		wt(30);
		chk("wdog fired", {31'h0, watchdog_expired_out}, 32'h1);
		axw(8'h00, 32'h0, rs);
		axw(8'h10, 32'h0, rs);
		wt(1);
		chk("wdog kicked", {30'h0, watchdog_expired_out, speaker_drive}, 32'h0);
		$display("watchdog test done");
		for (int t = 1; t < 4; t++) begin
			axw(8'h00, {26'h0, 2'(t), 4'h8}, rs);
			wt(1);
			chk("pending", {31'h0, lowpower_pending_n}, 32'h0);
			wt(10);
			chk("sleep lines", {29'h0, soft_off_state_n, disk_suspend_state_n,
				ram_suspend_state_n}, {29'h0, lo_exp[t - 1]});
			pin(wk[t - 1], 1'h0);
			pin(wk[t - 1], 1'h1);
			chk("woken", {29'h0, soft_off_state_n, disk_suspend_state_n,
				ram_suspend_state_n}, 32'h7);
		end
		pin(1, 1'h0);
		chk("button sleep", {31'h0, lowpower_pending_n}, 32'h0);
		pin(1, 1'h1);
		chk("button S3", {31'h0, ram_suspend_state_n}, 32'h0);
		pin(4, 1'h0);
		pin(4, 1'h1);
		chk("button woken", {31'h0, ram_suspend_state_n}, 32'h1);
		$display("sleep test done");
		axw(8'h00, 32'h4, rs);
		wt(2);
		chk("trip", {30'h0, overheat_shutdown_n, soft_off_state_n}, 32'h0);
		pin(2, 1'h0);
		pin(2, 1'h1);
		chk("trip held", {31'h0, soft_off_state_n}, 32'h0);
		@(posedge aclk);
		aresetn <= 1'h0;
		wt(3);
		rst_chk();
		chk("trip reset", {31'h0, overheat_shutdown_n}, 32'h1);
		@(posedge aclk);
		aresetn <= 1'h1;
		axr(8'h08, rd, rs);
		chk("fan reset", rd, 32'h80);
		axw(8'h08, 32'h0, rs);
		wt(2);
		chk("pwm zero", {31'h0, fan_speed_drive_oe}, 32'h1);
		$display("reset test done");
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
